// ### rtl/dsrxef_pkg.sv
// Package: offsets, field positions and codes of the receive error-count flags
package dsrxef_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] RX_CONTROL_REGISTER_OFS = 16'h0120;
  localparam logic [15:0] RX_ERROR_COUNT_FLAGS_OFS = 16'h0126;
  localparam logic [15:0] RX_STATUS1_OFS           = 16'h0124;
  localparam logic [15:0] REG_RESET                = 16'h0000;
  // ==========================================================
  // Field positions
  localparam int FERR_SEL_LSB   = 8;
  localparam int CPAR_BIT       = 3;
  localparam int FEBE_BIT       = 2;
  localparam int PPAR_BIT       = 1;
  localparam int FERR_BIT       = 0;
  localparam int LOS_BIT        = 0;
  localparam int CNT_W          = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  // ==========================================================
  // Framing error type selection
  typedef enum logic [1:0] {
    DSRXEF_SEL_OOF  = 2'h0,
    DSRXEF_SEL_MF   = 2'h1,
    DSRXEF_SEL_F    = 2'h2,
    DSRXEF_SEL_M    = 2'h3
  } dsrxef_sel_t;
endpackage : dsrxef_pkg

// ### rtl/dsrxef_counter.sv
// Saturating error counter with a synchronous clear input and a non-zero flag
`timescale 1ns/1ps
module dsrxef_counter
  import dsrxef_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  // Events
  input  wire logic             inc_i,
  input  wire logic             clr_i,
  // Status
  output logic [CNT_W-1:0]      count_o,
  output logic                  nonzero_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } dsrxef_cnt_state_t;

  dsrxef_cnt_state_t st;
  dsrxef_cnt_state_t next_st;

  always_comb
  begin
    next_st = st;
    // Event landing with the clear is kept as a count of one
    if (clr_i)
    begin
      next_st.cnt = inc_i ? CNT_ONE : CNT_ZERO;
    end
    else if (inc_i && (st.cnt != {CNT_W{1'b1}}))
    begin
      next_st.cnt = st.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      st.cnt <= CNT_ZERO;
    else
      st <= next_st;
  end

  assign count_o   = st.cnt;
  assign nonzero_o = (st.cnt != CNT_ZERO);
endmodule : dsrxef_counter

// ### rtl/dsrxef_top.sv
// Receive error-count flag register of the DS3 receive framer port
// Behaviour
// - Loss-of-signal flag follows the receive condition
// - Bit 3: C-bit parity count nonzero, M23 zero
// - Bit 2: far-end block count nonzero, M23 zero
// - Bit 1: P-bit parity count nonzero
// - Bit 0: framing error count nonzero
// - Framing event kind follows the select field
// - Select 00 OOF, 01 M+F, 10 F, 11 M
`timescale 1ns/1ps
module dsrxef_top
  import dsrxef_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  // Register port
  input  wire logic [15:0]      addr_i,
  input  wire logic [15:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic [15:0]           rdata_o,
  // Framer status and events
  input  wire logic             signal_absent_i,
  input  wire logic             m23_mode_i,
  input  wire logic             oof_start_i,
  input  wire logic             f_bit_err_i,
  input  wire logic             m_bit_err_i,
  input  wire logic             pbit_err_i,
  input  wire logic             cbit_err_i,
  input  wire logic             febe_i,
  // Count readout clears
  input  wire logic             clr_counts_i,
  // Flag outputs
  output logic                  signal_absent_flag_o,
  output logic                  cbit_parity_err_nonzero_o,
  output logic                  far_end_block_err_nonzero_o,
  output logic                  pbit_parity_err_nonzero_o,
  output logic                  framing_err_nonzero_o,
  output logic [1:0]            framing_err_type_select_o
);
  import dsrxef_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]  los_sync;
    // Bits beside the select field are stored for readback only
    logic [15:0] rx_control_register;
    logic        signal_absent_flag;
    logic        cpar;
    logic        febe;
    logic        ppar;
    logic        ferr;
    logic [15:0] rdata;
  } dsrxef_state_t;

  dsrxef_state_t st;
  dsrxef_state_t next_st;

  logic        ferr_evt;
  logic        cbit_evt;
  logic        febe_evt;
  logic        wr_ctrl;
  logic [3:0]  nz;
  logic [15:0] flags_word;
  logic [15:0] read_word;
  dsrxef_sel_t sel;

  assign sel = dsrxef_sel_t'(st.rx_control_register[FERR_SEL_LSB +: 2]);

  // ==========================================================
  // Framing event selection
  always_comb
  begin
    // decode of the two-bit select
    // Code 11 sits in the default arm so every code counts something
    case (sel)
      DSRXEF_SEL_OOF: ferr_evt = oof_start_i;
      DSRXEF_SEL_MF:  ferr_evt = f_bit_err_i | m_bit_err_i;
      DSRXEF_SEL_F:   ferr_evt = f_bit_err_i;
      default:        ferr_evt = m_bit_err_i;
    endcase
  end

  // ==========================================================
  // M23 gating of C-bit events
  // In M23 the C-bits carry stuffing, not parity or far-end
  // errors, so nothing is counted there
  assign cbit_evt = cbit_err_i & ~m23_mode_i;
  assign febe_evt = febe_i & ~m23_mode_i;

  // ==========================================================
  // Error counters
  // Counts saturate rather than wrap, so a long error burst can
  // never read back as a zero count
  dsrxef_counter u_cnt_ferr (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (ferr_evt),
    .clr_i     (clr_counts_i),
    .count_o   (),
    .nonzero_o (nz[0])
  );
  dsrxef_counter u_cnt_ppar (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (pbit_err_i),
    .clr_i     (clr_counts_i),
    .count_o   (),
    .nonzero_o (nz[1])
  );
  dsrxef_counter u_cnt_febe (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (febe_evt),
    .clr_i     (clr_counts_i),
    .count_o   (),
    .nonzero_o (nz[2])
  );
  dsrxef_counter u_cnt_cpar (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (cbit_evt),
    .clr_i     (clr_counts_i),
    .count_o   (),
    .nonzero_o (nz[3])
  );

  // ==========================================================
  // Flag word and register read decode
  always_comb
  begin
    flags_word = REG_RESET;
    flags_word[CPAR_BIT] = st.cpar;
    flags_word[FEBE_BIT] = st.febe;
    flags_word[PPAR_BIT] = st.ppar;
    flags_word[FERR_BIT] = st.ferr;
  end

  // Unmapped offsets read as zero rather than a stale word
  always_comb
  begin
    if (addr_i == RX_ERROR_COUNT_FLAGS_OFS)
      read_word = flags_word;
    else if (addr_i == RX_CONTROL_REGISTER_OFS)
      read_word = st.rx_control_register;
    else if (addr_i == RX_STATUS1_OFS)
    begin
      read_word          = REG_RESET;
      read_word[LOS_BIT] = st.signal_absent_flag;
    end
    else
      read_word = REG_RESET;
  end

  // Only the control register takes writes; the flag and status
  // words are views of live state with nothing behind them to set
  assign wr_ctrl = wr_i && (addr_i == RX_CONTROL_REGISTER_OFS);

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // Pin is asynchronous to the framer clock; the first stage may
    // go metastable, so only stages two and three are compared and
    // a one-cycle glitch on the pin never reaches the flag
    next_st.los_sync = {st.los_sync[1:0], signal_absent_i};
    // change accepted once stages two and three agree
    if (st.los_sync[2] == st.los_sync[1])
      next_st.signal_absent_flag = st.los_sync[1];
    // Flags lag the counters a cycle so each bit leaves a flop
    // C-bit parity flag, gated in M23
    next_st.cpar = nz[3] & ~m23_mode_i;
    // far-end block flag, gated in M23
    next_st.febe = nz[2] & ~m23_mode_i;
    // P-bit parity flag in both modes
    next_st.ppar = nz[1];
    next_st.ferr = nz[0];
    // writes to the flags offset have no target
    if (wr_ctrl)
      next_st.rx_control_register = wdata_i;
    // Read data is held until the next read strobe
    if (rd_i)
      next_st.rdata = read_word;
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st.los_sync            <= 3'h0;
      st.rx_control_register <= REG_RESET;
      st.signal_absent_flag                 <= 1'b0;
      st.cpar                <= 1'b0;
      st.febe                <= 1'b0;
      st.ppar                <= 1'b0;
      st.ferr                <= 1'b0;
      st.rdata               <= REG_RESET;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  // Every output is a register bit with no logic behind the flop
  assign rdata_o                     = st.rdata;
  assign signal_absent_flag_o        = st.signal_absent_flag;
  assign cbit_parity_err_nonzero_o   = st.cpar;
  assign far_end_block_err_nonzero_o = st.febe;
  assign pbit_parity_err_nonzero_o   = st.ppar;
  assign framing_err_nonzero_o       = st.ferr;
  assign framing_err_type_select_o   =
    st.rx_control_register[FERR_SEL_LSB +: 2];
endmodule : dsrxef_top

// ### tb/dsrxef_assertions.sv
// Checker on the receive error-count flag ports
`timescale 1ns/1ps
module dsrxef_chk (
  input wire logic        mclk_i, rst_b_i, rd_i, clr_counts_i,
  input wire logic        signal_absent_i, m23_mode_i, oof_start_i,
  input wire logic        pbit_err_i,
  input wire logic [15:0] addr_i, rdata_o,
  input wire logic        signal_absent_flag_o, cbit_parity_err_nonzero_o,
  input wire logic        far_end_block_err_nonzero_o,
  input wire logic        pbit_parity_err_nonzero_o, framing_err_nonzero_o,
  input wire logic [1:0]  framing_err_type_select_o
);
  logic [3:0] flg;
  assign flg = {cbit_parity_err_nonzero_o, far_end_block_err_nonzero_o,
                pbit_parity_err_nonzero_o, framing_err_nonzero_o};
  // ======================================
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Six cycles covers the synchroniser lag
  AST_LOS_SET: assert property (signal_absent_i [*6] |->
    signal_absent_flag_o) else $error("loss flag low");
  AST_LOS_CLR: assert property (!signal_absent_i [*6] |->
    !signal_absent_flag_o) else $error("loss flag high");
  AST_CPAR_M23: assert property (m23_mode_i [*3] |->
    !cbit_parity_err_nonzero_o) else $error("cbit flag in m23");
  AST_FEBE_M23: assert property (m23_mode_i [*3] |->
    !far_end_block_err_nonzero_o) else $error("febe flag in m23");
  AST_PPAR_SET: assert property (pbit_err_i ##1 !clr_counts_i [*3] |->
    pbit_parity_err_nonzero_o) else $error("pbit flag missing");
  AST_FERR_OOF: assert property ((oof_start_i &&
    framing_err_type_select_o == 2'h0) ##1 !clr_counts_i [*3]
    |-> framing_err_nonzero_o) else $error("framing flag missing");
  AST_RSVD_ZERO: assert property (rd_i && addr_i == 16'h0126 |=>
    rdata_o[15:4] == 12'h000) else $error("reserved bits set");
  AST_FLAG_READ: assert property (rd_i && addr_i == 16'h0126 |=>
    rdata_o[3:0] == $past(flg)) else $error("flag readout wrong");
  cover property (signal_absent_flag_o);
  cover property (m23_mode_i && pbit_parity_err_nonzero_o);
  cover property (framing_err_type_select_o == 2'h3 && flg[0]);
endmodule : dsrxef_chk
bind dsrxef_top dsrxef_chk dsrxef_chk_i (.*);

// ### tb/testbench.sv
// Self-checking bench of the receive error-count flags
`timescale 1ns/1ps
module testbench;
  import dsrxef_pkg::*;
  logic        mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
  logic        signal_absent_flag = 0, m23 = 0, clr = 0;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
  logic [5:0]  ev = 6'h00;
  logic [4:0]  fl;
  logic [1:0]  sel_o;
  int          n_mismatch = 0, total_checks = 0;
  always #4 mclk_i = ~mclk_i;
  dsrxef_top dsrxef_top_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .signal_absent_i(signal_absent_flag), .m23_mode_i(m23),
    .oof_start_i(ev[5]), .f_bit_err_i(ev[4]), .m_bit_err_i(ev[3]),
    .pbit_err_i(ev[2]), .cbit_err_i(ev[1]), .febe_i(ev[0]),
    .clr_counts_i(clr), .signal_absent_flag_o(fl[4]),
    .cbit_parity_err_nonzero_o(fl[3]),
    .far_end_block_err_nonzero_o(fl[2]),
    .pbit_parity_err_nonzero_o(fl[1]), .framing_err_nonzero_o(fl[0]),
    .framing_err_type_select_o(sel_o));
  // ======================================
  // Helpers
  task automatic tk(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tk
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    tk();
    wr_i = 0;
    rd_i = 0;
    tk();
  endtask : acc
  task automatic pulse(logic [5:0] e, logic c);
    ev = e;
    clr = c;
    tk();
    ev = 6'h00;
    clr = 0;
    tk(3);
  endtask : pulse
  // ======================================
  // Scenarios
  task automatic t_counts();
    pulse(6'h07, 0);
    acc(0, RX_ERROR_COUNT_FLAGS_OFS, 0);
    chk("flags", rdata_o, 16'h000e);
    // Entering M23 forces the C-bit flags low with the counts kept
    m23 = 1;
    tk(3);
    chk("m23 forced", 16'(fl), 16'h0002);
    m23 = 0;
    tk(2);
    chk("m23 left", 16'(fl), 16'h000e);
    m23 = 1;
    pulse(6'h00, 1);
    pulse(6'h07, 0);
    chk("m23 flags", 16'(fl), 16'h0002);
    m23 = 0;
    pulse(6'h00, 1);
    chk("cleared", 16'(fl), 16'h0000);
  endtask : t_counts
  task automatic t_sel();
    logic [2:0] hit [4] = '{3'b100, 3'b011, 3'b010, 3'b001};
    for (int s = 0; s < 4; s++)
    begin
      acc(1, RX_CONTROL_REGISTER_OFS, 16'(s) << FERR_SEL_LSB);
      chk("select", 16'(sel_o), 16'(s));
      for (int k = 0; k < 3; k++)
      begin
        pulse(6'h00, 1);
        pulse(6'h20 >> k, 0);
        chk("framing", 16'(fl[0]), 16'(hit[s][2-k]));
      end
    end
  endtask : t_sel
  task automatic t_ro();
    acc(1, RX_ERROR_COUNT_FLAGS_OFS, 16'hffff);
    acc(0, RX_ERROR_COUNT_FLAGS_OFS, 0);
    chk("read only", rdata_o, 16'h0001);
    acc(0, RX_CONTROL_REGISTER_OFS, 0);
    chk("control", rdata_o, 16'h0300);
    acc(0, 16'h0122, 0);
    chk("unmapped", rdata_o, 16'h0000);
  endtask : t_ro
  task automatic t_los();
    signal_absent_flag = 1;
    tk(6);
    chk("loss set", 16'(fl[4]), 16'h0001);
    acc(0, RX_STATUS1_OFS, 0);
    chk("status loss", rdata_o, 16'h0001);
    signal_absent_flag = 0;
    tk(6);
    chk("loss clear", 16'(fl[4]), 16'h0000);
  endtask : t_los
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    tk(4);
    rst_b_i = 1;
    tk();
    chk("reset flags", 16'(fl), 16'h0000);
    t_counts();
    t_sel();
    t_ro();
    t_los();
    wrap_up();
  end
endmodule : testbench
